// ---- dit_defs.svh ----
`ifndef DIT_DEFS_SVH
`define DIT_DEFS_SVH

// mode register addresses
`define DIT_MA_IO_CFG 6'h03
`define DIT_MA_TEMP 6'h04
`define DIT_MA_MAKER 6'h05

// reset values
`define DIT_IO_CFG_RST 8'h31
`define DIT_TEMP_CTL_RST 4'h0
`define DIT_RATE_RST 3'h3
`define DIT_MRR_IDLE 8'h00

// field positions in the op-code byte
`define DIT_IO_PROTECT_BIT 2
`define DIT_TEMP_TUF_BIT 7
`define DIT_TEMP_CTL_HI 6
`define DIT_TEMP_CTL_LO 3
`define DIT_TEMP_ENTRY_BIT 4
`define DIT_RATE_HI 2

// reserved codes
`define DIT_PULLDOWN_DRIVE_STRENGTH_RSV_LO 3'h0
`define DIT_PULLDOWN_DRIVE_STRENGTH_RSV_HI 3'h7
`define DIT_TOFS_RSV 2'h3

// identification code, arbitrary neutral value
`define DIT_MAKER_CODE 8'h5A

`endif

// ---- dit_pkg.sv ----
`default_nettype none

package dit_pkg;

  // mode register command from the command/address decoder
  typedef struct packed {
    logic mrw;
    logic mrr;
    logic [5:0] addr;
    logic [7:0] op;
  } dit_cmd_t;

  // mode register read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dit_mrr_t;

  // i/o configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic write_bus_inversion_en;
    logic read_bus_inversion_en;
    logic [2:0] pulldown_drive_strength;
    logic repair_protect;
    logic write_postamble_sel;
    logic pullup_cal_point;
  } dit_io_cfg_t;

  // writable part of the temperature register, bit 6 down to bit 3
  typedef struct packed {
    logic [1:0] thermal_offset;
    logic repair_entry;
    logic self_refresh_abort;
  } dit_temp_ctl_t;

  // refresh-rate codes
  typedef enum logic [2:0] {
    DIT_RATE_COLD_LIMIT = 3'h0,
    DIT_RATE_X4 = 3'h1,
    DIT_RATE_X2 = 3'h2,
    DIT_RATE_X1 = 3'h3,
    DIT_RATE_HALF = 3'h4,
    DIT_RATE_QUARTER = 3'h5,
    DIT_RATE_QUARTER_DERATE = 3'h6,
    DIT_RATE_HOT_LIMIT = 3'h7
  } dit_rate_t;

endpackage

`default_nettype wire

// ---- dit_mode_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dit_defs.svh"

module dit_mode_regs
  import dit_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = `DIT_MAKER_CODE // arbitrary value
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire dit_cmd_t cmd_in,
  input wire logic write_set_point_sel_in,
  input wire logic operating_set_point_sel_in,
  input wire logic init_done_in,
  input wire logic [2:0] sensor_rate_in,
  input wire logic derate_req_in,
  output var dit_mrr_t mrr_out,
  output var dit_io_cfg_t active_io_cfg_out,
  output var dit_temp_ctl_t temp_ctl_out,
  output logic [2:0] refresh_rate_out,
  output logic temp_update_flag_out,
  output logic above_85c_out,
  output logic mrw_refused_out
);

  // merge a write into one i/o copy; a reserved drive code keeps the old one
  function automatic dit_io_cfg_t io_merge(input dit_io_cfg_t old_cfg,
                                           input logic [7:0] op);
    dit_io_cfg_t res;
    res = dit_io_cfg_t'(op);
    if ((res.pulldown_drive_strength == `DIT_PULLDOWN_DRIVE_STRENGTH_RSV_LO) ||
        (res.pulldown_drive_strength == `DIT_PULLDOWN_DRIVE_STRENGTH_RSV_HI))
    begin
      res.pulldown_drive_strength = old_cfg.pulldown_drive_strength;
    end
    // protection lives in one sticky flop shared by both copies
    res.repair_protect = 1'b0;
    return res;
  endfunction

  // insert the sticky protection bit into a copy for reads and operation
  function automatic dit_io_cfg_t io_view(input dit_io_cfg_t cfg,
                                          input logic protect);
    dit_io_cfg_t res;
    res = cfg;
    res.repair_protect = protect;
    return res;
  endfunction

  dit_io_cfg_t io_copy0_ff;
  dit_io_cfg_t io_copy1_ff;
  dit_io_cfg_t nxt_io_copy0;
  dit_io_cfg_t nxt_io_copy1;
  dit_io_cfg_t active_io_ff;
  dit_io_cfg_t io_rd_view;
  dit_io_cfg_t io_wr_val;
  dit_temp_ctl_t temp_ctl_ff;
  dit_temp_ctl_t nxt_temp_ctl;
  dit_temp_ctl_t temp_wr_val;
  dit_mrr_t mrr_ff;
  logic protect_ff;
  logic nxt_protect;
  logic [2:0] rate_ff;
  logic [2:0] nxt_rate;
  logic [2:0] sensed_rate;
  logic tuf_ff;
  logic nxt_tuf;
  logic refused_ff;
  logic [7:0] rd_data;

  // command decode
  wire io_wr = cmd_in.mrw && (cmd_in.addr == `DIT_MA_IO_CFG);
  wire temp_wr_hit = cmd_in.mrw && (cmd_in.addr == `DIT_MA_TEMP);
  wire temp_rd = cmd_in.mrr && (cmd_in.addr == `DIT_MA_TEMP);
  wire entry_req = cmd_in.op[`DIT_TEMP_ENTRY_BIT];
  // the whole write is dropped, so no side field changes behind a refusal
  wire entry_blocked = temp_wr_hit && protect_ff && entry_req;
  wire temp_wr = temp_wr_hit && !entry_blocked;
  wire io_wr0 = io_wr && !write_set_point_sel_in;
  wire io_wr1 = io_wr && write_set_point_sel_in;
  assign io_wr_val = dit_io_cfg_t'(cmd_in.op);

  // set-point copies: only the write-selected one takes the write
  assign nxt_io_copy0 = io_wr0 ? io_merge(io_copy0_ff, cmd_in.op) : io_copy0_ff;
  assign nxt_io_copy1 = io_wr1 ? io_merge(io_copy1_ff, cmd_in.op) : io_copy1_ff;

  // protection only ever sets; a write of 0 has no path to clear it
  assign nxt_protect = protect_ff | (io_wr & cmd_in.op[`DIT_IO_PROTECT_BIT]);

  // temperature register write: bits 6..3 only, reserved offset keeps old value
  assign temp_wr_val = dit_temp_ctl_t'(cmd_in.op[`DIT_TEMP_CTL_HI:`DIT_TEMP_CTL_LO]);
  always_comb
  begin
    nxt_temp_ctl = temp_ctl_ff;
    if (temp_wr)
    begin
      nxt_temp_ctl.self_refresh_abort = temp_wr_val.self_refresh_abort;
      nxt_temp_ctl.repair_entry = temp_wr_val.repair_entry;
      if (temp_wr_val.thermal_offset != `DIT_TOFS_RSV)
      begin
        nxt_temp_ctl.thermal_offset = temp_wr_val.thermal_offset;
      end
    end
  end

  // sensor code; the 0.25x region turns into the derated code on request
  assign sensed_rate = (derate_req_in && (sensor_rate_in == DIT_RATE_QUARTER)) ?
                       DIT_RATE_QUARTER_DERATE : sensor_rate_in;

  // rate holds its default until initialization is done
  assign nxt_rate = init_done_in ? sensed_rate : rate_ff;

  // a change sets the flag even in the cycle of a read, so no change is lost
  assign nxt_tuf = (nxt_rate != rate_ff) | (tuf_ff & ~temp_rd);

  // read data select
  assign io_rd_view = io_view(write_set_point_sel_in ? io_copy1_ff : io_copy0_ff,
                              protect_ff);
  assign rd_data =
    (cmd_in.addr == `DIT_MA_IO_CFG) ? 8'(io_rd_view) :
    (cmd_in.addr == `DIT_MA_TEMP) ? {tuf_ff, temp_ctl_ff, rate_ff} :
    (cmd_in.addr == `DIT_MA_MAKER) ? MAKER_CODE :
    `DIT_MRR_IDLE;

  // i/o configuration copies and sticky protection
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      io_copy0_ff <= dit_io_cfg_t'(`DIT_IO_CFG_RST);
      io_copy1_ff <= dit_io_cfg_t'(`DIT_IO_CFG_RST);
      protect_ff <= 1'b0;
    end
    else
    begin
      io_copy0_ff <= nxt_io_copy0;
      io_copy1_ff <= nxt_io_copy1;
      protect_ff <= nxt_protect;
    end
  end

  // operating copy, taken from next values so a write shows on the same edge as in the copy
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      active_io_ff <= dit_io_cfg_t'(`DIT_IO_CFG_RST);
    end
    else
    begin
      active_io_ff <= io_view(operating_set_point_sel_in ? nxt_io_copy1 : nxt_io_copy0,
                              nxt_protect);
    end
  end

  // temperature register
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      temp_ctl_ff <= dit_temp_ctl_t'(`DIT_TEMP_CTL_RST);
      rate_ff <= `DIT_RATE_RST;
      tuf_ff <= 1'b0;
    end
    else
    begin
      temp_ctl_ff <= nxt_temp_ctl;
      rate_ff <= nxt_rate;
      tuf_ff <= nxt_tuf;
    end
  end

  // read answer and refusal pulse, one edge after the command
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      mrr_ff <= '0;
      refused_ff <= 1'b0;
    end
    else
    begin
      mrr_ff.valid <= cmd_in.mrr;
      mrr_ff.data <= cmd_in.mrr ? rd_data : `DIT_MRR_IDLE;
      refused_ff <= entry_blocked;
    end
  end

  // outputs
  assign mrr_out = mrr_ff;
  assign active_io_cfg_out = active_io_ff;
  assign temp_ctl_out = temp_ctl_ff;
  assign refresh_rate_out = rate_ff;
  assign temp_update_flag_out = tuf_ff;
  assign above_85c_out = rate_ff[`DIT_RATE_HI];
  assign mrw_refused_out = refused_ff;

  // protection never falls once set
  a_protect_sticky: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    protect_ff |=> protect_ff)
    else $error("repair protection cleared without reset");

  // a refused write leaves the whole temperature control untouched
  a_entry_refused: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (temp_wr_hit && protect_ff && entry_req) |=>
      (temp_ctl_out == $past(temp_ctl_out)) && mrw_refused_out)
    else $error("repair entry write taken while protected");

  // an accepted write sets repair entry to the written bit
  a_entry_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    temp_wr |=> temp_ctl_out.repair_entry == $past(entry_req))
    else $error("repair entry does not follow write");

  // reserved drive codes leave the drive code of set point 0 unchanged
  a_pulldown_drive_strength_reserved: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (io_wr0 && (cmd_in.op[5:3] == `DIT_PULLDOWN_DRIVE_STRENGTH_RSV_LO || cmd_in.op[5:3] == `DIT_PULLDOWN_DRIVE_STRENGTH_RSV_HI))
      |=> $stable(io_copy0_ff.pulldown_drive_strength))
    else $error("reserved drive strength stored");

  // a write to set point 1 leaves set point 0 alone
  a_copy_isolation: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    io_wr1 |=> $stable(io_copy0_ff))
    else $error("write reached the unselected copy");

  // operation follows the copy chosen by the operating select
  a_active_copy: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ##1 (active_io_cfg_out.pulldown_drive_strength ==
      ($past(operating_set_point_sel_in) ? io_copy1_ff.pulldown_drive_strength :
                                           io_copy0_ff.pulldown_drive_strength)))
    else $error("active copy is not the operating one");

  // any change of the rate raises the flag on the same edge; a reset is no change
  a_tuf_set: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (!$past(reset_in) && (refresh_rate_out != $past(refresh_rate_out))) |->
      temp_update_flag_out)
    else $error("rate changed without update flag");

  // a read with no fresh change clears the flag and returns the old one
  a_tuf_clear: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (temp_rd && (nxt_rate == rate_ff)) |=>
      !temp_update_flag_out && (mrr_out.data[`DIT_TEMP_TUF_BIT] == $past(tuf_ff)))
    else $error("update flag not cleared by read");

  // before initialization the rate stays put, and so does the flag unless a temperature read clears it
  a_rate_before_init: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (!init_done_in && !temp_rd) |=> $stable(refresh_rate_out) && $stable(temp_update_flag_out))
    else $error("rate moved before initialization");

  // derating request in the 0.25x region reports code 6
  a_derate_code: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (init_done_in && derate_req_in && sensor_rate_in == DIT_RATE_QUARTER) |=>
      refresh_rate_out == DIT_RATE_QUARTER_DERATE)
    else $error("derating not reported");

  // identification read always returns the maker code
  a_maker_read: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (cmd_in.mrr && cmd_in.addr == `DIT_MA_MAKER) |=>
      mrr_out.valid && (mrr_out.data == MAKER_CODE))
    else $error("maker code read wrong");

  // a temperature write never touches the rate or the flag bits
  a_temp_wr_mask: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (temp_wr && !init_done_in && !temp_rd) |=>
      $stable(refresh_rate_out) && $stable(temp_update_flag_out))
    else $error("temperature write reached read-only bits");

  // setting the protect bit in either copy turns protection on
  a_protect_set: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (io_wr && io_wr_val.repair_protect) |=> protect_ff)
    else $error("repair protection not set by write");

  // the postamble select lands in set point 0 as given
  a_postamble_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    io_wr0 |=> io_copy0_ff.write_postamble_sel == $past(io_wr_val.write_postamble_sel))
    else $error("postamble select not stored");

  // bus inversion enables and pull-up point land in set point 1 as written
  a_io_fields: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    io_wr1 |=>
      (io_copy1_ff.write_bus_inversion_en == $past(io_wr_val.write_bus_inversion_en)) &&
      (io_copy1_ff.read_bus_inversion_en == $past(io_wr_val.read_bus_inversion_en)) &&
      (io_copy1_ff.pullup_cal_point == $past(io_wr_val.pullup_cal_point)))
    else $error("i/o configuration fields not stored");

  // an i/o read shows the selected drive code and the shared protect bit
  a_io_read: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (cmd_in.mrr && cmd_in.addr == `DIT_MA_IO_CFG) |=>
      (mrr_out.data[`DIT_IO_PROTECT_BIT] == $past(protect_ff)) &&
      (mrr_out.data[5:3] == ($past(write_set_point_sel_in) ?
        $past(io_copy1_ff.pulldown_drive_strength) :
        $past(io_copy0_ff.pulldown_drive_strength))))
    else $error("i/o read shows the wrong copy");

  // temperature read returns the rate and flag as they stood
  a_temp_read: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    temp_rd |=> mrr_out.valid && (mrr_out.data[2:0] == $past(refresh_rate_out)) &&
      (mrr_out.data[`DIT_TEMP_TUF_BIT] == $past(temp_update_flag_out)))
    else $error("temperature read data wrong");

  // codes above 1x mean above 85 C; 1x and below do not
  a_hot_code: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    above_85c_out == (refresh_rate_out > DIT_RATE_X1))
    else $error("above-85 indication wrong");

  // right after reset the flag is clear and the rate sits at 1x
  a_tuf_reset: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $past(reset_in) |-> !temp_update_flag_out && (refresh_rate_out == DIT_RATE_X1))
    else $error("flag or rate wrong after reset");

  // reserved thermal offset keeps the old offset
  a_offset_reserved: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (temp_wr && temp_wr_val.thermal_offset == `DIT_TOFS_RSV) |=>
      $stable(temp_ctl_out.thermal_offset))
    else $error("reserved thermal offset stored");

  // self-refresh abort follows an accepted write
  a_abort_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    temp_wr |=> temp_ctl_out.self_refresh_abort == $past(temp_wr_val.self_refresh_abort))
    else $error("self-refresh abort does not follow write");

  // a write to the identification register changes no state
  a_maker_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (cmd_in.mrw && cmd_in.addr == `DIT_MA_MAKER) |=>
      $stable(io_copy0_ff) && $stable(io_copy1_ff) && $stable(temp_ctl_ff) && $stable(protect_ff))
    else $error("identification write changed state");

endmodule

`default_nettype wire

// ---- dit_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module dit_ctrl_model
  import dit_pkg::*;
#(
  parameter int CK_MHZ = 100,
  parameter int BASE_REFI_NS = 3900
)
(
  input wire logic sys_clk_in,
  input wire dit_mrr_t mrr_in,
  input wire logic refused_in,
  output var dit_cmd_t cmd_out
);
  int refi_ns = BASE_REFI_NS;

  initial cmd_out = '0;

  // refresh interval follows the reported multiplier
  function automatic int scale_refi(input logic [2:0] r);
    case (r)
      3'h1: scale_refi = BASE_REFI_NS * 4;
      3'h2: scale_refi = BASE_REFI_NS * 2;
      3'h4: scale_refi = BASE_REFI_NS / 2;
      3'h5, 3'h6: scale_refi = BASE_REFI_NS / 4;
      default: scale_refi = BASE_REFI_NS;
    endcase
  endfunction

  // long postamble is only legal on fast clocks, so a slow controller clears it
  function automatic logic [7:0] legal_io(input logic [7:0] op);
    legal_io = op;
    if (CK_MHZ <= 1600)
    begin
      legal_io[1] = 1'b0;
    end
  endfunction

  // one command, optional idle gap first; released lines show the inverse
  task automatic issue(input logic wr, input logic [5:0] addr, input logic [7:0] op,
                       input int gap, output logic vld, output logic [7:0] data,
                       output logic refused);
    repeat (gap) @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    cmd_out <= '{mrw: wr, mrr: ~wr, addr: addr, op: op};
    @(posedge sys_clk_in);
    cmd_out <= '{mrw: 1'b0, mrr: 1'b0, addr: ~addr, op: ~op};
    #1;
    vld = mrr_in.valid;
    data = mrr_in.data;
    refused = refused_in;
    if (!wr && addr == 6'h04)
    begin
      refi_ns = scale_refi(data[2:0]);
    end
  endtask
endmodule

`default_nettype wire

// ---- test_dram_io_temp_mode_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dit_defs.svh"

module test_dram_io_temp_mode_regs;
  import dit_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wsel = 1'b0;
  logic osel = 1'b0;
  logic init_done = 1'b0;
  logic derate = 1'b0;
  logic [2:0] sensor = 3'h3;
  dit_cmd_t cmd;
  dit_mrr_t mrr;
  dit_io_cfg_t act;
  dit_temp_ctl_t ctl;
  logic [2:0] rate;
  logic flag;
  logic hot;
  logic refused;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 32'h0E9E5A1E;
  localparam int REFI_NS = 3900;
  logic [7:0] copy_q [2] = '{8'h31, 8'h31};
  logic prot_q = 1'b0;
  logic [3:0] ctl_q = 4'h0;
  logic [7:0] op;
  logic [2:0] ex;

  dit_mode_regs u_dit_mode_regs (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .cmd_in(cmd),
    .write_set_point_sel_in(wsel), .operating_set_point_sel_in(osel),
    .init_done_in(init_done), .sensor_rate_in(sensor), .derate_req_in(derate),
    .mrr_out(mrr), .active_io_cfg_out(act), .temp_ctl_out(ctl), .refresh_rate_out(rate),
    .temp_update_flag_out(flag), .above_85c_out(hot), .mrw_refused_out(refused));
  dit_ctrl_model #(.BASE_REFI_NS(REFI_NS)) u_dit_ctrl_model (.sys_clk_in(sys_clk_in), .mrr_in(mrr),
    .refused_in(refused), .cmd_out(cmd));

  always #5 sys_clk_in = ~sys_clk_in;

  // a hang is cut short well past the few hundred cycles the run needs
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_int(input int got, input int exp, input string what);
    check_count++;
    if (got != exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // refresh interval stretched or shrunk by the reported multiplier
  function automatic int refi_exp(input logic [2:0] r);
    case (r)
      3'h1: refi_exp = REFI_NS * 4;
      3'h2: refi_exp = REFI_NS * 2;
      3'h4: refi_exp = REFI_NS / 2;
      3'h5, 3'h6: refi_exp = REFI_NS / 4;
      default: refi_exp = REFI_NS;
    endcase
  endfunction

  // reserved drive-strength codes leave the stored code alone
  function automatic logic [7:0] io_next(input logic [7:0] old, input logic [7:0] o);
    io_next = o;
    if (o[5:3] == 3'h0 || o[5:3] == 3'h7)
      io_next[5:3] = old[5:3];
  endfunction

  // the protect bit is one sticky flag seen through both copies
  function automatic logic [7:0] io_view(input logic [7:0] c);
    io_view = {c[7:3], prot_q, c[1:0]};
  endfunction

  // reserved thermal offset keeps the old offset
  function automatic logic [3:0] temp_next(input logic [3:0] old, input logic [7:0] o);
    temp_next = o[6:3];
    if (o[6:5] == 2'b11)
      temp_next[3:2] = old[3:2];
  endfunction

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic v;
    logic [7:0] d;
    logic f;
    u_dit_ctrl_model.issue(1'b0, a, 8'h00, {$random(seed)} % 3, v, d, f);
    check_val({7'h00, v}, 8'h01, "read valid");
    check_val(d, exp, "read data");
  endtask

  task automatic wr_io(input logic [7:0] o);
    logic v;
    logic [7:0] d;
    logic f;
    o = u_dit_ctrl_model.legal_io(o);
    u_dit_ctrl_model.issue(1'b1, `DIT_MA_IO_CFG, o, {$random(seed)} % 3, v, d, f);
    copy_q[wsel] = io_next(copy_q[wsel], o);
    prot_q = prot_q | o[2];
  endtask

  task automatic wr_temp(input logic [7:0] o);
    logic v;
    logic [7:0] d;
    logic f;
    u_dit_ctrl_model.issue(1'b1, `DIT_MA_TEMP, o, {$random(seed)} % 3, v, d, f);
    check_val({7'h00, f}, {7'h00, prot_q & o[4]}, "refused pulse");
    if (!(prot_q && o[4]))
      ctl_q = temp_next(ctl_q, o);
    check_val({4'h0, ctl}, {4'h0, ctl_q}, "temp controls");
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    check_val(act, 8'h31, "active reset");
    rd_chk(`DIT_MA_IO_CFG, 8'h31);
    @(posedge sys_clk_in);
    sensor <= 3'h6;
    rd_chk(`DIT_MA_TEMP, 8'h03);
    u_dit_ctrl_model.issue(1'b1, `DIT_MA_MAKER, 8'($random(seed)), 0, op[0], op, op[1]);
    rd_chk(`DIT_MA_MAKER, `DIT_MAKER_CODE);
    // both copies, reserved drive strengths in the mix
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk_in);
      wsel <= i[0];
      op = 8'($random(seed));
      op[2] = 1'b0;
      if (i == 2)
        op[5:3] = 3'h0;
      if (i == 3)
        op[5:3] = 3'h7;
      wr_io(op);
      rd_chk(`DIT_MA_IO_CFG, io_view(copy_q[i % 2]));
    end
    for (int s = 0; s < 2; s++)
    begin
      @(posedge sys_clk_in);
      osel <= s[0];
      repeat (2) @(posedge sys_clk_in);
      #1;
      check_val(act, io_view(copy_q[s]), "active copy");
    end
    for (int i = 0; i < 6; i++)
    begin
      op = 8'($random(seed));
      op[4] = (i == 1);
      if (i == 2)
        op[6:5] = 2'b11;
      wr_temp(op);
      rd_chk(`DIT_MA_TEMP, {1'b0, ctl_q, 3'h3});
    end
    wr_io(8'h34);
    wr_io(8'h30);
    rd_chk(`DIT_MA_IO_CFG, io_view(copy_q[1]));
    wr_temp(8'h10);
    wr_temp(8'h48);
    @(posedge sys_clk_in);
    init_done <= 1'b1;
    // every rate code, then derating on the quarter-rate code
    for (int i = 0; i < 9; i++)
    begin
      @(posedge sys_clk_in);
      sensor <= (i == 8) ? 3'h5 : i[2:0];
      derate <= (i == 8);
      ex = (i == 8) ? 3'h6 : i[2:0];
      repeat (2) @(posedge sys_clk_in);
      #1;
      check_val({5'h00, rate}, {5'h00, ex}, "rate");
      check_val({7'h00, hot}, {7'h00, ex[2]}, "hot");
      check_val({7'h00, flag}, 8'h01, "flag set");
      rd_chk(`DIT_MA_TEMP, {1'b1, ctl_q, ex});
      check_int(u_dit_ctrl_model.refi_ns, refi_exp(ex), "refresh interval");
      rd_chk(`DIT_MA_TEMP, {1'b0, ctl_q, ex});
    end
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    prot_q = 1'b0;
    rd_chk(`DIT_MA_IO_CFG, 8'h31);
    final_report();
  end
endmodule

`default_nettype wire
